// ---- hdl/printer_escape_command_handler.sv ----
// printer_escape_command_handler: command byte parser, image, macro and cut control
// assumes an Avalon-MM master and a print engine on the same 50 MHz clock
`timescale 1ns/1ns
module printer_escape_command_handler #(
   parameter logic [23:0] WAIT_CYCLES = cp::WAIT_CYCLES,
   parameter logic [23:0] BLINK_CYCLES = cp::BLINK_CYCLES
) (
   input logic clock,
   input logic resetn,
   input logic [3:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   input logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input logic line_busy,
   input logic glyph_define,
   input logic paper_advance_switch,
   output cp::stream_t stream,
   output cp::img_job_t job,
   output logic barcode_legend_text,
   output logic [1:0] align,
   output logic full_cut,
   output logic part_cut,
   output logic glyph_clear,
   output logic fault_lamp,
   output logic feed_enable
);
   logic [1:0] rst_q;
   logic rst_n;
   cp::state_t s;
   cp::state_t n;
   logic [7:0] mem [0:2047];
   logic [7:0] mem_q;
   logic mem_we;
   logic busy;
   logic host_take;
   logic take;
   logic allow;
   logic last;
   logic fire;
   logic press;
   logic [7:0] b;
   logic [1:0] need;
   logic [11:0] dots;

   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // macro store: a plain array, written only while recording
   always_ff @(posedge clock) begin
      if (mem_we) begin
         mem[s.len[10:0]] <= avs_writedata[7:0];
      end
      mem_q <= mem[s.ptr[10:0]];
   end

   ////////////////////////////////////////////////////////////////////////////
   // host bytes stall while a macro runs, so replay and host never mix
   assign busy = s.rs != cp::R_IDLE;
   assign host_take = avs_write && avs_byteenable[0] && avs_address == cp::REG_DATA && !busy;
   assign take = host_take || s.play_q;
   assign b = s.play_q ? mem_q : avs_writedata[7:0];
   assign allow = s.host_en || s.play_q;
   assign press = s.sw_lvl && !s.sw_prev;
   assign fire = take && s.ps == cp::P_PARAM && last;
   assign last = s.pidx == need - 2'h1;
   assign dots = {1'b0, s.img_w, 3'h0} << b[0];
   assign avs_waitrequest = (avs_read && !s.rd_ack)
      || (avs_write && avs_address == cp::REG_DATA && busy);

   always_comb begin
      if (s.cmd == cp::IMG_DEF_CODE) begin
         need = 2'h2;
      end else if (s.cmd == cp::RUN_CODE) begin
         need = 2'h3;
      end else begin
         need = 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = s;
      n.out.valid = 1'b0;
      n.job.start = 1'b0;
      n.full_cut = 1'b0;
      n.part_cut = 1'b0;
      n.glyph_clear = 1'b0;
      mem_we = 1'b0;
      // reads answer on the second edge so readdata comes from a flop
      n.rd_ack = avs_read && !s.rd_ack;
      if (avs_read && !s.rd_ack) begin
         if (avs_address == cp::REG_STATUS) begin
            n.rdata = {23'h0, s.lamp, busy, s.rec, s.mvalid, s.img_valid, s.align,
               s.font, s.host_en};
         end else if (avs_address == cp::REG_IMAGE) begin
            n.rdata = {14'h0, s.last_mode, s.img_h, s.img_w};
         end else if (avs_address == cp::REG_MACRO) begin
            n.rdata = {12'h0, s.count, s.len};
         end else begin
            n.rdata = 32'h0;
         end
      end
      // switch: only the 2nd and 3rd flops are compared
      n.sw = {s.sw[1:0], paper_advance_switch};
      if (s.sw[1] == s.sw[2]) begin
         n.sw_lvl = s.sw[2];
      end
      n.sw_prev = s.sw_lvl;
      // recording keeps host bytes; excess beyond the store is dropped
      if (host_take && s.rec && s.host_en) begin
         n.gs_kept = 1'b0;
         if (s.len < cp::MACRO_BYTES) begin
            mem_we = 1'b1;
            n.len = s.len + 12'h1;
            n.gs_kept = b == cp::GROUP_BYTE && s.ps == cp::P_IDLE;
         end
      end
      ////////////////////////////////////////////////////////////////////////
      case (s.rs)
         cp::R_WAIT: begin
            if (s.wcnt == s.wait_n) begin
               n.rs = s.mode ? cp::R_SWITCH : cp::R_PLAY;
               n.ptr = 12'h0;
               n.bcnt = 24'h0;
            end else if (s.tick == WAIT_CYCLES - 24'h1) begin
               n.tick = 24'h0;
               n.wcnt = s.wcnt + 8'h1;
            end else begin
               n.tick = s.tick + 24'h1;
            end
         end
         cp::R_SWITCH: begin
            if (s.bcnt == BLINK_CYCLES - 24'h1) begin
               n.bcnt = 24'h0;
               n.lamp = !s.lamp;
            end else begin
               n.bcnt = s.bcnt + 24'h1;
            end
            if (press) begin
               n.rs = cp::R_PLAY;
               n.lamp = 1'b0;
            end
         end
         cp::R_PLAY: begin
            n.play_q = s.ptr < s.len;
            if (s.ptr < s.len) begin
               n.ptr = s.ptr + 12'h1;
            end else if (!s.play_q) begin
               n.count = s.count - 8'h1;
               n.rs = s.count == 8'h1 ? cp::R_IDLE : cp::R_WAIT;
               n.tick = 24'h0;
               n.wcnt = 8'h0;
            end
         end
         default: begin
         end
      endcase
      ////////////////////////////////////////////////////////////////////////
      // an image that completes in the same cycle as a glyph define still counts
      if (glyph_define) begin
         n.img_valid = 1'b0;
      end
      if (take) begin
         case (s.ps)
            cp::P_IDLE: begin
               if (b == cp::ESCAPE_BYTE) begin
                  n.ps = cp::P_ESCAPE;
               end else if (b == cp::GROUP_BYTE) begin
                  n.ps = cp::P_GROUP;
               end else if (allow) begin
                  n.out = {1'b1, 1'b0, b};
               end
            end
            cp::P_ESCAPE: begin
               n.cmd = b;
               n.pidx = 2'h0;
               n.ps = cp::P_IDLE;
               if (b == cp::INPUT_CODE || b == cp::ALIGN_CODE) begin
                  n.ps = cp::P_PARAM;
               end else if (allow && b == cp::INIT_CODE) begin
                  n.font = cp::FONT_RST;
                  n.align = cp::ALIGN_RST;
                  n.host_en = cp::HOST_EN_RST;
                  n.img_valid = 1'b0;
               end else if (allow && !line_busy) begin
                  n.full_cut = b == cp::FULL_CUT_CODE;
                  n.part_cut = b == cp::PART_CUT_CODE;
               end
            end
            cp::P_GROUP: begin
               n.cmd = b;
               n.pidx = 2'h0;
               n.ps = cp::P_IDLE;
               if (b == cp::FONT_CODE || b == cp::IMG_DEF_CODE || b == cp::IMG_PRT_CODE
                  || b == cp::RUN_CODE) begin
                  n.ps = cp::P_PARAM;
               end else if (b == cp::RECORD_CODE && !s.play_q && s.host_en) begin
                  n.rec = !s.rec;
                  n.gs_kept = 1'b0;
                  if (s.rec) begin
                     // the closing prefix byte is not part of the macro
                     n.len = s.len - {11'h0, s.gs_kept};
                     n.mvalid = s.len != {11'h0, s.gs_kept};
                  end else begin
                     n.len = 12'h0;
                     n.mvalid = 1'b0;
                  end
               end
            end
            cp::P_PARAM: begin
               n.pidx = s.pidx + 2'h1;
               if (s.pidx == 2'h0) begin
                  n.p0 = b;
               end
               if (s.pidx == 2'h1) begin
                  n.p1 = b;
               end
               if (last) begin
                  n.ps = cp::P_IDLE;
                  if (s.cmd == cp::INPUT_CODE) begin
                     n.host_en = b[0];
                  end else if (allow) begin
                     case (s.cmd)
                        cp::FONT_CODE: begin
                           n.font = b[0];
                        end
                        cp::ALIGN_CODE: begin
                           if (!line_busy && b <= cp::MAX_ALIGN) begin
                              n.align = b[1:0];
                           end
                        end
                        cp::IMG_PRT_CODE: begin
                           if (s.img_valid && !line_busy && b <= cp::MAX_MODE) begin
                              n.job.start = 1'b1;
                              n.job.mode = b[1:0];
                              n.job.cols = dots > cp::LINE_DOTS ? cp::LINE_DOTS : dots;
                              n.last_mode = b[1:0];
                           end
                        end
                        cp::IMG_DEF_CODE: begin
                           if (s.p0 != 8'h0 && b != 8'h0 && b <= cp::MAX_HEIGHT) begin
                              n.img_w = s.p0;
                              n.img_h = b;
                              n.img_valid = 1'b0;
                              n.glyph_clear = 1'b1;
                              n.left = 19'(s.p0) * 19'(b) * 19'h8;
                              n.ps = cp::P_DATA;
                           end
                        end
                        cp::RUN_CODE: begin
                           if (s.play_q) begin
                              // nested runs from inside a macro are ignored
                           end else if (s.rec) begin
                              n.rec = 1'b0;
                              n.len = 12'h0;
                              n.mvalid = 1'b0;
                           end else if (s.mvalid && s.p0 != 8'h0) begin
                              n.rs = cp::R_WAIT;
                              n.count = s.p0;
                              n.wait_n = s.p1;
                              n.mode = b[0];
                              n.tick = 24'h0;
                              n.wcnt = 8'h0;
                           end
                        end
                        default: begin
                        end
                     endcase
                  end
               end
            end
            cp::P_DATA: begin
               n.out = {allow, 1'b1, b};
               n.left = s.left - 19'h1;
               if (s.left == 19'h1) begin
                  n.ps = cp::P_IDLE;
                  n.img_valid = 1'b1;
               end
            end
            default: begin
               n.ps = cp::P_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.host_en <= cp::HOST_EN_RST;
         s.font <= cp::FONT_RST;
         s.align <= cp::ALIGN_RST;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign avs_readdata = s.rdata;
   assign stream = s.out;
   assign job = s.job;
   assign barcode_legend_text = s.font;
   assign align = s.align;
   assign full_cut = s.full_cut;
   assign part_cut = s.part_cut;
   assign glyph_clear = s.glyph_clear;
   assign fault_lamp = s.lamp;
   // the feed key is handed to a run in switch mode for the whole run, from its first wait until it ends
   assign feed_enable = !(busy && s.mode);

   ////////////////////////////////////////////////////////////////////////////
   property p_font;
      fire && allow && s.cmd == cp::FONT_CODE |=> s.font == $past(b[0]);
   endproperty
   a_font: assert property (p_font) else $error("legend font not taken");

   property p_input;
      fire && s.cmd == cp::INPUT_CODE |=> s.host_en == $past(b[0]);
   endproperty
   a_input: assert property (p_input) else $error("input gate not taken");

   property p_print;
      s.job.start |-> $past(s.img_valid) && !$past(line_busy);
   endproperty
   a_print: assert property (p_print) else $error("image print not refused");

   property p_clip;
      s.job.start |-> s.job.cols <= cp::LINE_DOTS && s.job.cols != 12'h0;
   endproperty
   a_clip: assert property (p_clip) else $error("image columns not clipped");

   property p_len;
      s.len <= cp::MACRO_BYTES;
   endproperty
   a_len: assert property (p_len) else $error("macro exceeds store");

   property p_abort;
      fire && allow && !s.play_q && s.cmd == cp::RUN_CODE && s.rec
         |=> !s.rec && !s.mvalid && s.len == 12'h0 && s.rs == cp::R_IDLE;
   endproperty
   a_abort: assert property (p_abort) else $error("recording not aborted");

   property p_skip;
      fire && !s.play_q && s.cmd == cp::RUN_CODE && !s.rec && (!s.mvalid || s.p0 == 8'h0)
         |=> s.rs == cp::R_IDLE;
   endproperty
   a_skip: assert property (p_skip) else $error("empty macro run started");

   property p_feed;
      s.rs == cp::R_SWITCH |-> !feed_enable && s.mode;
   endproperty
   a_feed: assert property (p_feed) else $error("feed key live in run");

   property p_cut;
      full_cut || part_cut |-> !$past(line_busy) && $past(s.ps) == cp::P_ESCAPE;
   endproperty
   a_cut: assert property (p_cut) else $error("cut away from line start");

   property p_wait;
      s.rs != cp::R_WAIT && $past(s.rs) == cp::R_WAIT |-> $past(s.wcnt) == $past(s.wait_n);
   endproperty
   a_wait: assert property (p_wait) else $error("wait ended early");

   property p_lamp;
      s.rs != cp::R_SWITCH |=> !fault_lamp || s.rs == cp::R_SWITCH;
   endproperty
   a_lamp: assert property (p_lamp) else $error("lamp lit outside wait");

   property p_glyph;
      glyph_clear |-> s.ps == cp::P_DATA && !s.img_valid;
   endproperty
   a_glyph: assert property (p_glyph) else $error("glyph clear without define");
endmodule // printer_escape_command_handler

// ---- include/cp.sv ----
// cp: constants, types and the state record of the printer command handler
// assumes a 50 MHz clock and a byte-addressed Avalon-MM slave port
package cp;
   localparam logic [7:0] ESCAPE_BYTE = 8'h1b;
   localparam logic [7:0] GROUP_BYTE = 8'h1d;
   localparam logic [7:0] FONT_CODE = 8'h66;
   localparam logic [7:0] IMG_DEF_CODE = 8'h2a;
   localparam logic [7:0] IMG_PRT_CODE = 8'h2f;
   localparam logic [7:0] RECORD_CODE = 8'h3a;
   localparam logic [7:0] RUN_CODE = 8'h5e;
   localparam logic [7:0] INPUT_CODE = 8'h3d;
   localparam logic [7:0] ALIGN_CODE = 8'h61;
   localparam logic [7:0] FULL_CUT_CODE = 8'h69;
   localparam logic [7:0] PART_CUT_CODE = 8'h6d;
   localparam logic [7:0] INIT_CODE = 8'h40;
   localparam logic [3:0] REG_DATA = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_IMAGE = 4'h8;
   localparam logic [3:0] REG_MACRO = 4'hc;
   localparam logic [11:0] MACRO_BYTES = 12'h800;
   localparam logic [11:0] LINE_DOTS = 12'h200;
   localparam logic [7:0] MAX_HEIGHT = 8'h48;
   localparam logic [7:0] MAX_ALIGN = 8'h02;
   localparam logic [7:0] MAX_MODE = 8'h03;
   localparam logic HOST_EN_RST = 1'b1;
   localparam logic FONT_RST = 1'b0;
   localparam logic [1:0] ALIGN_RST = 2'h0;
   localparam int CLOCK_HZ = 50_000_000;
   localparam int WAIT_UNIT_MS = 100;
   localparam int BLINK_MS = 250;
   localparam logic [23:0] WAIT_CYCLES = 24'(CLOCK_HZ / 1000 * WAIT_UNIT_MS);
   localparam logic [23:0] BLINK_CYCLES = 24'(CLOCK_HZ / 1000 * BLINK_MS);
   typedef enum logic [2:0] {
      P_IDLE = 3'h0, P_ESCAPE = 3'h1, P_GROUP = 3'h3, P_PARAM = 3'h2, P_DATA = 3'h6
   } parse_t;
   typedef enum logic [1:0] {
      R_IDLE = 2'h0, R_WAIT = 2'h1, R_SWITCH = 2'h3, R_PLAY = 2'h2
   } run_t;
   typedef struct packed {
      logic valid;
      logic image;
      logic [7:0] data;
   } stream_t;
   typedef struct packed {
      logic start;
      logic [1:0] mode;
      logic [11:0] cols;
   } img_job_t;
   typedef struct packed {
      parse_t ps;
      logic [7:0] cmd;
      logic [1:0] pidx;
      logic [7:0] p0;
      logic [7:0] p1;
      logic font;
      logic [1:0] align;
      logic host_en;
      logic img_valid;
      logic [7:0] img_w;
      logic [7:0] img_h;
      logic [1:0] last_mode;
      logic [18:0] left;
      logic rec;
      logic mvalid;
      logic [11:0] len;
      logic gs_kept;
      run_t rs;
      logic mode;
      logic [7:0] count;
      logic [7:0] wait_n;
      logic [7:0] wcnt;
      logic [23:0] tick;
      logic [11:0] ptr;
      logic play_q;
      logic lamp;
      logic [23:0] bcnt;
      logic [2:0] sw;
      logic sw_lvl;
      logic sw_prev;
      logic rd_ack;
      logic [31:0] rdata;
      stream_t out;
      img_job_t job;
      logic full_cut;
      logic part_cut;
      logic glyph_clear;
   } state_t;
endpackage

// ---- tb/paper_path_model.sv ----
// paper_path_model: line buffer level and the operator at the paper advance switch
// assumes the handler's clock; the bench decides when the line holds data
`timescale 1ns/1ns
module paper_path_model (
   input wire logic clock,
   input wire logic hold,
   input wire logic fault_lamp,
   output logic line_busy,
   output logic paper_advance_switch
);
   logic [3:0] cnt = 4'h0;
   assign line_busy = hold;
   ////////////////////////////////////////////////////////////
   // operator reacts late on purpose, so the lamp must keep blinking meanwhile
   always @(posedge clock) begin
      if (fault_lamp && cnt == 4'h0) begin
         cnt <= 4'h1;
      end else if (cnt != 4'h0) begin
         cnt <= cnt + 4'h1;
      end
      paper_advance_switch <= (cnt >= 4'h6);
   end
endmodule // paper_path_model

// ---- tb/test_printer_escape_command_handler.sv ----
// test_printer_escape_command_handler: self-checking bench of the command handler
// assumes the handler, its package and the paper path model; 50 MHz clock
`timescale 1ns/1ns
module test_printer_escape_command_handler;
   logic clock, resetn, avs_read, avs_write, avs_waitrequest, hold, line_busy;
   logic glyph_define, paper_advance_switch, barcode_legend_text, full_cut, part_cut;
   logic glyph_clear, fault_lamp, feed_enable;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdv;
   logic [1:0] align;
   cp::stream_t stream;
   cp::img_job_t job;
   logic [15:0] q[5][$];
   logic [7:0] rnd = 8'h2c;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   int last_cut = 0;
   int gap = 0;
   printer_escape_command_handler #(.WAIT_CYCLES(24'h000014), .BLINK_CYCLES(24'h000004)) dut_u (
      .clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .line_busy(line_busy), .glyph_define(glyph_define),
      .paper_advance_switch(paper_advance_switch), .stream(stream), .job(job),
      .barcode_legend_text(barcode_legend_text), .align(align), .full_cut(full_cut),
      .part_cut(part_cut), .glyph_clear(glyph_clear), .fault_lamp(fault_lamp),
      .feed_enable(feed_enable));
   paper_path_model partner_u (.clock(clock), .hold(hold), .fault_lamp(fault_lamp),
      .line_busy(line_busy), .paper_advance_switch(paper_advance_switch));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic exp(input int k, input logic [15:0] v);
      q[k].push_back(v);
   endtask
   task automatic take(input int k, input logic [15:0] v);
      logic [15:0] e;
      e = (q[k].size() > 0) ? q[k].pop_front() : 16'hffff;
      chk("result", {16'(k), e}, {16'(k), v});
   endtask
   // write is left high between bytes, so a burst never pulses the strobe twice in one step
   task automatic wr(input logic [7:0] d);
      avs_write <= 1'b1;
      avs_address <= cp::REG_DATA;
      avs_writedata <= {24'h0, d};
      do @(posedge clock); while (avs_waitrequest);
   endtask
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) wr(b[i]);
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      avs_read <= 1'b1;
      avs_address <= a;
      do @(posedge clock); while (avs_waitrequest);
      v = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask
   task automatic define(input logic [7:0] w);
      exp(4, 16'h0);
      wr(cp::GROUP_BYTE);
      wr(cp::IMG_DEF_CODE);
      wr(w);
      wr(cp::MAX_HEIGHT);
      repeat (int'(w) * 8 * int'(cp::MAX_HEIGHT)) begin
         rnd = lfsr(rnd);
         exp(0, {8'h01, rnd});
         wr(rnd);
      end
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic final_report;
      foreach (q[k]) chk("notes left", 32'h0, 32'(q[k].size()));
      $display("checks %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // outputs are looked at mid-cycle, where the registered pulses have settled
   always @(negedge clock) begin
      cyc++;
      if (resetn) begin
         if (stream.valid) take(0, {7'h0, stream.image, stream.data});
         if (job.start) take(1, {2'h0, job.mode, job.cols});
         if (full_cut) begin
            take(2, 16'h0);
            gap = cyc - last_cut;
            last_cut = cyc;
         end
         if (part_cut) take(3, 16'h0);
         if (glyph_clear) take(4, 16'h0);
      end
   end
   initial begin
      repeat (90000) @(posedge clock);
      err_total++;
      final_report();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      hold = 1'b0;
      glyph_define = 1'b0;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      rd(cp::REG_STATUS, rdv);
      chk("status", 32'h1, rdv);
      for (int f = 1; f >= 0; f--) begin
         send('{cp::GROUP_BYTE, cp::FONT_CODE, 8'(f)});
         chk("legend", 32'(f), 32'(barcode_legend_text));
      end
      for (int a = 2; a >= 0; a--) begin
         send('{cp::ESCAPE_BYTE, cp::ALIGN_CODE, 8'(a)});
         chk("align", 32'(a), 32'(align));
      end
      exp(2, 16'h0);
      send('{cp::ESCAPE_BYTE, cp::FULL_CUT_CODE});
      exp(3, 16'h0);
      send('{cp::ESCAPE_BYTE, cp::PART_CUT_CODE});
      send('{cp::GROUP_BYTE, cp::IMG_PRT_CODE, 8'h00});
      define(8'h02);
      for (int m = 0; m < 4; m++) begin
         exp(1, {2'h0, 2'(m), 12'(m[0] ? 32 : 16)});
         send('{cp::GROUP_BYTE, cp::IMG_PRT_CODE, 8'(m)});
      end
      hold <= 1'b1;
      send('{cp::ESCAPE_BYTE, cp::ALIGN_CODE, 8'h01, cp::ESCAPE_BYTE, cp::FULL_CUT_CODE});
      send('{cp::ESCAPE_BYTE, cp::PART_CUT_CODE, cp::GROUP_BYTE, cp::IMG_PRT_CODE, 8'h00});
      chk("align", 32'h0, 32'(align));
      hold <= 1'b0;
      glyph_define <= 1'b1;
      @(posedge clock);
      glyph_define <= 1'b0;
      send('{cp::GROUP_BYTE, cp::IMG_PRT_CODE, 8'h00});
      define(8'h50);
      exp(1, 16'h1200);
      send('{cp::GROUP_BYTE, cp::IMG_PRT_CODE, 8'h01});
      rd(cp::REG_IMAGE, rdv);
      chk("image regs", 32'h00014850, rdv);
      send('{cp::ESCAPE_BYTE, cp::INIT_CODE, cp::GROUP_BYTE, cp::IMG_PRT_CODE, 8'h00});
      send('{cp::ESCAPE_BYTE, cp::INPUT_CODE, 8'hfe, 8'h41});
      rd(cp::REG_STATUS, rdv);
      chk("host enable", 32'h0, {31'h0, rdv[0]});
      exp(0, 16'h0042);
      send('{cp::ESCAPE_BYTE, cp::INPUT_CODE, 8'h01, 8'h42});
      wr(cp::GROUP_BYTE);
      wr(cp::RECORD_CODE);
      repeat (2050) begin
         rnd = lfsr(rnd);
         exp(0, {10'h001, rnd[5:0]});
         wr({2'b01, rnd[5:0]});
      end
      send('{cp::GROUP_BYTE, cp::RECORD_CODE});
      rd(cp::REG_MACRO, rdv);
      chk("macro length", 32'h800, {20'h0, rdv[11:0]});
      exp(2, 16'h0);
      send('{cp::GROUP_BYTE, cp::RECORD_CODE, cp::ESCAPE_BYTE, cp::FULL_CUT_CODE});
      send('{cp::GROUP_BYTE, cp::RUN_CODE, 8'h01, 8'h00, 8'h00});
      rd(cp::REG_STATUS, rdv);
      chk("macro state", 32'h0, {30'h0, rdv[6:5]});
      send('{cp::GROUP_BYTE, cp::RUN_CODE, 8'h01, 8'h00, 8'h00});
      exp(2, 16'h0);
      send('{cp::GROUP_BYTE, cp::RECORD_CODE, cp::ESCAPE_BYTE, cp::FULL_CUT_CODE});
      send('{cp::GROUP_BYTE, cp::RECORD_CODE, cp::ESCAPE_BYTE, cp::INIT_CODE});
      rd(cp::REG_STATUS, rdv);
      chk("macro kept", 32'h1, {31'h0, rdv[5]});
      exp(2, 16'h0);
      exp(2, 16'h0);
      send('{cp::GROUP_BYTE, cp::RUN_CODE, 8'h02, 8'h01, 8'h00});
      send('{cp::GROUP_BYTE, cp::RUN_CODE, 8'h00, 8'h01, 8'h00});
      chk("run gap", 32'h1, 32'(gap >= 20 && gap <= 28));
      exp(2, 16'h0);
      fork
         send('{cp::GROUP_BYTE, cp::RUN_CODE, 8'h01, 8'h00, 8'h01});
         begin
            @(negedge clock iff fault_lamp);
            chk("feed enable", 32'h0, 32'(feed_enable));
         end
      join
      // the run ends only after the operator press; poll the busy bit until then
      do rd(cp::REG_STATUS, rdv); while (rdv[7]);
      chk("lamp", 32'h0, 32'(fault_lamp));
      chk("feed enable", 32'h1, 32'(feed_enable));
      repeat (4) @(posedge clock);
      final_report();
   end
endmodule // test_printer_escape_command_handler
